// ---- common/sdram_init_pkg.sv ----
// Package with constants and types for the SDRAM init and mapping block.
package sdram_init_pkg;

  // ==========================================================
  // Widths and field positions.
  // ==========================================================
  localparam int addr_w = 28;
  localparam int sd_addr_w = 13;
  localparam int count_w = 12;
  localparam int col_lsb = 1;
  localparam logic [3:0] ap_bit = 4'ha;

  // ==========================================================
  // Mode field encodings.
  // ==========================================================
  localparam logic [2:0] mode_normal = 3'h0;
  localparam logic [2:0] mode_nop = 3'h1;
  localparam logic [2:0] mode_prech = 3'h2;
  localparam logic [2:0] mode_mrs = 3'h3;
  localparam logic [2:0] mode_refresh = 3'h4;
  localparam logic [2:0] mode_emrs = 3'h5;

  // ==========================================================
  // Reset values.
  // ==========================================================
  localparam logic [count_w-1:0] count_reset = 12'h000;

  // Command encoding on chip select, row, column and write enable.
  typedef enum logic [3:0] {
    cmd_inhibit = 4'hf,
    cmd_nop = 4'h7,
    cmd_active = 4'h3,
    cmd_read = 4'h5,
    cmd_write = 4'h4,
    cmd_precharge = 4'h2,
    cmd_refresh = 4'h1,
    cmd_load_mode = 4'h0
  } sd_cmd_t;

  // Command word driven toward the memory, sent as one group.
  typedef struct packed {
    sd_cmd_t cmd;
    logic [1:0] bank;
    logic [sd_addr_w-1:0] addr;
  } sd_bus_t;

endpackage

// ---- hw/sdram_init_ctrl.sv ----
// SDRAM init sequencing, half-word address mapping and refresh timer.
`timescale 1ns/10ps
`default_nettype none
module sdram_init_ctrl
  import sdram_init_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic sd_clock,
  input wire logic [2:0] mode_setting,
  input wire logic [count_w-1:0] refresh_count_setting,
  input wire logic [1:0] col_bits_setting,
  input wire logic [1:0] row_bits_setting,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [addr_w-1:0] acc_addr,
  output logic acc_ready,
  input wire logic status_read,
  output logic refresh_error,
  output logic [1:0] half_word_byte_select,
  output var sd_bus_t sd_bus
);

  // ==========================================================
  // Address mapping.
  // ==========================================================
  // Columns start at bit 1; bit 0 only picks the byte in the half-word.
  function automatic sd_bus_t map_addr(input logic [addr_w-1:0] a,
                                        input logic [1:0] cb,
                                        input logic [1:0] rb);
    sd_bus_t r;
    int nc;
    int nr;
    logic [addr_w-1:0] s;
    r = '0;
    nc = 8 + int'(cb);
    nr = 11 + int'(rb);
    s = a >> (col_lsb + nc);
    r.addr = sd_addr_w'(s) & sd_addr_w'((1 << nr) - 1);
    s = s >> nr;
    r.bank = {s[1], s[0]};
    r.cmd = cmd_active;
    return r;
  endfunction

  // Column field: the bits just above the byte select, sized by setting.
  // The row word above carries no column, so this is kept on its own.
  function automatic logic [sd_addr_w-1:0] col_of(
      input logic [addr_w-1:0] a, input logic [1:0] cb);
    int nc;
    nc = 8 + int'(cb);
    return sd_addr_w'(a >> col_lsb) & sd_addr_w'((1 << nc) - 1);
  endfunction

  // ==========================================================
  // System side: access requests cross to the memory clock.
  // ==========================================================
  // Request handshake: toggle from the system side, ack back.
  logic req_tog_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_tog_r;
  logic req_s1_r;
  logic req_s2_r;
  logic req_seen_r;
  logic busy_r;
  sd_bus_t req_word_r;
  logic [1:0] byte_r;
  logic [sd_addr_w-1:0] col_r; // Column of the access in flight.

  // Combinational ready while no request is in flight.
  assign acc_ready = !busy_r;

  // Capture an access and launch its toggle toward the link side.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      req_tog_r <= 1'b0;
      busy_r <= 1'b0;
      req_word_r <= '0;
      byte_r <= 2'h0;
      col_r <= '0;
    end else if (acc_valid && !busy_r) begin
      req_tog_r <= !req_tog_r;
      busy_r <= 1'b1;
      req_word_r <= map_addr(acc_addr, col_bits_setting,
                             row_bits_setting);
      req_word_r.cmd <= acc_write ? cmd_write : cmd_read;
      byte_r <= acc_addr[0] ? 2'h2 : 2'h1;
      col_r <= col_of(acc_addr, col_bits_setting);
      if (acc_write) begin
        unique case (mode_setting)
          mode_nop: req_word_r.cmd <= cmd_nop;
          mode_prech: req_word_r.cmd <= cmd_precharge;
          mode_refresh: req_word_r.cmd <= cmd_refresh;
          mode_mrs: req_word_r.cmd <= cmd_load_mode;
          mode_emrs: req_word_r.cmd <= cmd_load_mode;
          default: req_word_r.cmd <= cmd_write;
        endcase
      end
    end else if (ack_s2_r == req_tog_r) begin
      busy_r <= 1'b0;
    end
  end

  // Ack synchroniser back into the system domain.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_tog_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  // Byte lanes are a data output and come from a flip-flop.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      half_word_byte_select <= 2'h0;
    end else begin
      half_word_byte_select <= byte_r;
    end
  end

  // ==========================================================
  // Refresh timer in the system domain.
  // ==========================================================
  // A zero count stops periodic refresh until software programs it.
  logic [count_w-1:0] timer_r;
  logic ref_due_r;
  logic ref_tog_r;
  logic ref_done_s1_r;
  logic ref_done_s2_r;
  logic ref_done_tog_r;
  logic ref_done_d_r;
  wire logic tick = (refresh_count_setting != count_reset) &&
                    (timer_r == count_reset);
  wire logic done_pulse = ref_done_s2_r ^ ref_done_d_r;

  // Reload the timer from the programmed count at each expiry.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_r <= count_reset;
    end else if (tick || refresh_count_setting == count_reset) begin
      timer_r <= refresh_count_setting;
    end else begin
      timer_r <= timer_r - 1'b1;
    end
  end

  // Pending refresh and its toggle to the link side.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_due_r <= 1'b0;
      ref_tog_r <= 1'b0;
    end else if (tick) begin
      ref_due_r <= 1'b1;
      ref_tog_r <= !ref_tog_r;
    end else if (done_pulse) begin
      ref_due_r <= 1'b0;
    end
  end

  // Sticky error; a new miss wins over a status read.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      refresh_error <= 1'b0;
    end else if (tick && ref_due_r && !done_pulse) begin
      refresh_error <= 1'b1;
    end else if (status_read) begin
      refresh_error <= 1'b0;
    end
  end

  // Completion synchroniser for the refresh handshake.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_done_s1_r <= 1'b0;
      ref_done_s2_r <= 1'b0;
      ref_done_d_r <= 1'b0;
    end else begin
      ref_done_s1_r <= ref_done_tog_r;
      ref_done_s2_r <= ref_done_s1_r;
      ref_done_d_r <= ref_done_s2_r;
    end
  end

  // ==========================================================
  // Memory clock domain.
  // ==========================================================
  // The memory clock runs free, so every edge may be counted on.
  logic ref_s1_r;
  logic ref_s2_r;
  logic ref_seen_r;
  logic col_phase_r; // Row is open; the column command goes next.
  wire logic new_req = req_s2_r ^ req_seen_r;
  wire logic new_ref = ref_s2_r ^ ref_seen_r;

  // Input synchronisers on the memory clock.
  always_ff @(posedge sd_clock or negedge resetn) begin
    if (!resetn) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
    end else begin
      req_s1_r <= req_tog_r;
      req_s2_r <= req_s1_r;
      ref_s1_r <= ref_tog_r;
      ref_s2_r <= ref_s1_r;
    end
  end

  // Command issue: one command per cycle, refresh before a new access; the access
  // word is stable while busy, so it is safe to read here.
  always_ff @(posedge sd_clock or negedge resetn) begin
    if (!resetn) begin
      sd_bus <= '{cmd: cmd_inhibit, bank: 2'h0, addr: '0};
      req_seen_r <= 1'b0;
      ack_tog_r <= 1'b0;
      ref_seen_r <= 1'b0;
      ref_done_tog_r <= 1'b0;
      col_phase_r <= 1'b0;
    end else if (col_phase_r) begin
      // The column step cannot wait behind a refresh: its row is open.
      sd_bus <= req_word_r;
      sd_bus.addr <= col_r;
      col_phase_r <= 1'b0;
      ack_tog_r <= !ack_tog_r;
    end else if (new_ref) begin
      sd_bus <= '{cmd: cmd_refresh, bank: 2'h0, addr: '0};
      ref_seen_r <= ref_s2_r;
      ref_done_tog_r <= !ref_done_tog_r;
    end else if (new_req) begin
      sd_bus <= req_word_r;
      if (req_word_r.cmd == cmd_precharge) begin
        sd_bus.addr[ap_bit] <= 1'b1;
      end
      req_seen_r <= req_s2_r;
      if (req_word_r.cmd == cmd_write || req_word_r.cmd == cmd_read) begin
        // A data access opens its row first; the column follows.
        sd_bus.cmd <= cmd_active;
        col_phase_r <= 1'b1;
      end else begin
        ack_tog_r <= !ack_tog_r;
      end
    end else begin
      sd_bus <= '{cmd: cmd_nop, bank: 2'h0, addr: '0};
    end
  end

  // ==========================================================
  // Checks.
  // ==========================================================
  property ready_drop_p;
    @(posedge clock) disable iff (!resetn)
      acc_valid && acc_ready |=> !acc_ready;
  endproperty
  ready_drop_a: assert property (ready_drop_p)
    else $error("ready stayed high after accepted access");

  property err_clear_p;
    @(posedge clock) disable iff (!resetn)
      status_read && !tick |=> !refresh_error;
  endproperty
  status_clear_a: assert property (err_clear_p)
    else $error("refresh error not cleared by status read");

  property zero_quiet_p;
    @(posedge clock) disable iff (!resetn)
      refresh_count_setting == count_reset |=> $stable(ref_tog_r);
  endproperty
  zero_count_a: assert property (zero_quiet_p)
    else $error("refresh tick with zero count");

  property nop_map_p;
    @(posedge clock) disable iff (!resetn)
      acc_valid && acc_ready && acc_write && mode_setting == mode_nop
      |=> req_word_r.cmd == cmd_nop;
  endproperty
  nop_mode_a: assert property (nop_map_p)
    else $error("mode 1 write did not queue a nop");

  property refresh_map_p;
    @(posedge clock) disable iff (!resetn)
      acc_valid && acc_ready && acc_write && mode_setting == mode_refresh
      |=> req_word_r.cmd == cmd_refresh;
  endproperty
  refresh_mode_a: assert property (refresh_map_p)
    else $error("mode 4 write did not queue a refresh");

  property byte_sel_p;
    @(posedge clock) disable iff (!resetn)
      acc_valid && acc_ready
      |=> byte_r == ($past(acc_addr[0]) ? 2'h2 : 2'h1);
  endproperty
  byte_select_a: assert property (byte_sel_p)
    else $error("byte lane does not follow address bit 0");

  property error_on_miss_p;
    @(posedge clock) disable iff (!resetn)
      tick && ref_due_r && !done_pulse |=> refresh_error;
  endproperty
  miss_flag_a: assert property (error_on_miss_p)
    else $error("missed refresh not flagged");

  property reload_p;
    @(posedge clock) disable iff (!resetn)
      tick |=> timer_r == $past(refresh_count_setting);
  endproperty
  timer_reload_a: assert property (reload_p)
    else $error("timer not reloaded from count");

  // A row open on the link is followed at once by its column command.
  sequence row_open_s;
    sd_bus.cmd == cmd_active;
  endsequence
  sequence col_cmd_s;
    sd_bus.cmd == cmd_write || sd_bus.cmd == cmd_read;
  endsequence
  property act_then_col_p;
    @(posedge sd_clock) disable iff (!resetn)
      row_open_s |=> col_cmd_s;
  endproperty
  row_then_col_a: assert property (act_then_col_p)
    else $error("row open not followed by column command");

  // Precharge always targets every bank.
  property prech_all_p;
    @(posedge sd_clock) disable iff (!resetn)
      sd_bus.cmd == cmd_precharge |-> sd_bus.addr[ap_bit];
  endproperty
  prech_all_a: assert property (prech_all_p)
    else $error("precharge without all-banks bit");

endmodule
`default_nettype wire

// ---- dv/sdram_cmd_model.sv ----
// Behavioural model of the attached memory that logs the commands it sees.
`timescale 1ns/10ps
`default_nettype none
module sdram_cmd_model
  import sdram_init_pkg::*;
(
  input wire logic sd_clock,
  input wire logic resetn,
  input wire sd_bus_t sd_bus,
  output var sd_bus_t last_word,
  output var sd_bus_t act_word,
  output logic [15:0] n_cmd,
  output logic [15:0] n_ref
);
  // ==========================================================
  // Command log.
  // ==========================================================
  // A no-operation leaves no trace here, so that step shows only
  // as an unchanged command count.
  always_ff @(posedge sd_clock or negedge resetn) begin
    if (!resetn) begin
      last_word <= '0;
      act_word <= '0;
      n_cmd <= 16'h0000;
      n_ref <= 16'h0000;
    end else if (sd_bus.cmd != cmd_nop && sd_bus.cmd != cmd_inhibit) begin
      n_cmd <= n_cmd + 16'h0001;
      last_word <= sd_bus;
      // Row opens are kept apart, since a write or read follows them.
      if (sd_bus.cmd == cmd_active) begin
        act_word <= sd_bus;
      end
      if (sd_bus.cmd == cmd_refresh) begin
        n_ref <= n_ref + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/sdram_init_and_half_word_mapping_test.sv ----
// Testbench for the SDRAM init sequencing and half-word mapping block.
`timescale 1ns/10ps
`default_nettype none
module sdram_init_and_half_word_mapping_test
  import sdram_init_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals.
  // ==========================================================
  logic clock, sd_clock, resetn, acc_valid, acc_write, acc_ready;
  logic status_read, refresh_error;
  logic [2:0] mode_setting;
  logic [count_w-1:0] refresh_count_setting;
  logic [1:0] col_bits_setting, row_bits_setting, half_word_byte_select;
  logic [addr_w-1:0] acc_addr;
  sd_bus_t sd_bus, last_word, act_word;
  logic [15:0] n_cmd, n_ref, n0;
  int n_errors, checked, i, c, r, cw, rw;
  logic [27:0] a, colv, rowv;
  logic [1:0] bk;

  sdram_init_ctrl u_sdram_init_ctrl (.clock(clock), .resetn(resetn),
    .sd_clock(sd_clock), .mode_setting(mode_setting),
    .refresh_count_setting(refresh_count_setting),
    .col_bits_setting(col_bits_setting), .row_bits_setting(row_bits_setting),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_ready(acc_ready), .status_read(status_read),
    .refresh_error(refresh_error),
    .half_word_byte_select(half_word_byte_select), .sd_bus(sd_bus));
  sdram_cmd_model u_sdram_cmd_model (.sd_clock(sd_clock), .resetn(resetn),
    .sd_bus(sd_bus), .last_word(last_word), .act_word(act_word),
    .n_cmd(n_cmd), .n_ref(n_ref));

  // The link clock starts off phase so its edges never meet the system's.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    sd_clock = 1'b0;
    #37;
    forever #80 sd_clock = ~sd_clock;
  end

  // ==========================================================
  // Shared tasks.
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One write access in the given mode; returns once the memory has
  // logged the command, so the model's record may be compared at once.
  task automatic access(input logic [2:0] mode, input logic [27:0] adr);
    int k;
    mode_setting = mode;
    acc_addr = adr;
    acc_write = 1'b1;
    k = 0;
    // Ready changes only on a rising edge, so it is settled here.
    while (acc_ready !== 1'b1 && k < 100) begin
      k++;
      @(negedge clock);
    end
    acc_valid = 1'b1;
    @(posedge clock);
    @(negedge clock);
    acc_valid = 1'b0;
    while (acc_ready !== 1'b1 && k < 2000) begin
      k++;
      @(negedge clock);
    end
    // The model logs a command one link edge after it goes out.
    repeat (2) @(posedge sd_clock);
    @(negedge clock);
    if (k >= 2000) begin
      n_errors++;
      conclude();
    end
  endtask

  // ==========================================================
  // Main sequence.
  // ==========================================================
  initial begin
    n_errors = 0;
    checked = 0;
    resetn = 1'b0;
    // Pins belong to the controller.
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = 28'h0000000;
    status_read = 1'b0;
    mode_setting = mode_normal;
    refresh_count_setting = 12'h000;
    // Sizes and types are set before any command is requested.
    col_bits_setting = 2'h1;
    row_bits_setting = 2'h1;
    // Reset is asynchronous, so the link side clears without an edge.
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    repeat (25000) @(negedge clock);
    check(refresh_error, 1'b0);
    n0 = n_cmd;
    access(mode_nop, 28'h0000000);
    check(n_cmd, n0);
    access(mode_prech, 28'h0000000);
    check(last_word.cmd, cmd_precharge);
    check(last_word.addr[ap_bit], 1'b1);
    for (i = 0; i < 8; i++) access(mode_refresh, 28'h0000000);
    check(n_ref, 16'h0008);
    access(mode_mrs, 28'h0000000);
    check(last_word.cmd, cmd_load_mode);
    check(last_word.bank, 2'h0);
    access(mode_emrs, 28'h0800000);
    check(last_word.cmd, cmd_load_mode);
    check(last_word.bank, 2'h2);
    access(mode_normal, 28'h0000000);
    check(last_word.cmd, cmd_write);
    // Every column size with row sizes 0 to 2, with the byte lane and bank index varied.
    for (c = 0; c < 4; c++) begin
      for (r = 0; r < 3; r++) begin
        cw = 8 + c;
        rw = 11 + r;
        bk = 2'(c + r);
        col_bits_setting = 2'(c);
        row_bits_setting = 2'(r);
        colv = 28'h2a5 & ((28'h1 << cw) - 28'h1);
        rowv = 28'h1b3c & ((28'h1 << rw) - 28'h1);
        a = (28'(bk) << (1 + cw + rw)) | (rowv << (1 + cw)) | (colv << 1);
        a[0] = c[0] ^ r[0];
        access(mode_normal, a);
        check(last_word.cmd, cmd_write);
        check(last_word.bank, bk);
        check(last_word.addr & 13'h3ff, colv);
        check(act_word.addr, rowv);
        check(act_word.bank, bk);
        check(half_word_byte_select, a[0] ? 2'h2 : 2'h1);
      end
    end
    // Periodic refresh every 97 clocks (count 96): about ten in 1000 clocks.
    refresh_count_setting = 12'h060;
    n0 = n_ref;
    repeat (1000) @(negedge clock);
    check((n_ref - n0) >= 16'h0008 && (n_ref - n0) <= 16'h000b, 1'b1);
    // A zero count must leave the memory quiet; a refresh already on
    // its way across the link needs a few link cycles to land.
    refresh_count_setting = 12'h000;
    repeat (200) @(negedge clock);
    n0 = n_ref;
    repeat (1000) @(negedge clock);
    check(n_ref, n0);
    // A count far too short to keep up forces a missed refresh.
    refresh_count_setting = 12'h001;
    i = 0;
    while (refresh_error !== 1'b1 && i < 500) begin
      i++;
      @(negedge clock);
    end
    check(refresh_error, 1'b1);
    refresh_count_setting = 12'h000;
    repeat (100) @(negedge clock);
    check(refresh_error, 1'b1);
    status_read = 1'b1;
    @(negedge clock);
    status_read = 1'b0;
    @(negedge clock);
    check(refresh_error, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
